//--- dbsac_pkg.sv
// ****************************************
// organizations and widths
// ****************************************
package dbsac_pkg;

    localparam int unsigned ORG_X8 = 0;
    localparam int unsigned ORG_X9 = 1;
    localparam int unsigned ORG_X18 = 2;
    localparam int unsigned ORG_X36 = 3;

    localparam int unsigned DW_X8 = 8;
    localparam int unsigned DW_X9 = 9;
    localparam int unsigned DW_X18 = 18;
    localparam int unsigned DW_X36 = 36;

    localparam int unsigned EXT_AW_X8 = 21;
    localparam int unsigned EXT_AW_X9 = 21;
    localparam int unsigned EXT_AW_X18 = 21;
    localparam int unsigned EXT_AW_X36 = 20;

    // depth of each of the two internal arrays, in words
    localparam int unsigned ARRAY_DEPTH_X8 = 2097152;
    localparam int unsigned ARRAY_DEPTH_X9 = 2097152;
    localparam int unsigned ARRAY_DEPTH_X18 = 1048576;
    localparam int unsigned ARRAY_DEPTH_X36 = 524288;

    localparam int unsigned NUM_ARRAYS = 2;
    localparam int unsigned BURST_LEN = 2;
    localparam int unsigned SYNC_STAGES = 2;

    localparam logic DQ_OE_OFF = 1'h1;

    // ****************************************
    // state encodings
    // ****************************************
    typedef enum logic [1:0] {
        RD_IDLE = 2'h0,
        RD_WORD1 = 2'h1,
        RD_TAIL = 2'h2
    } dbsac_rd_st_t;

    typedef enum logic [1:0] {
        WR_IDLE = 2'h0,
        WR_LO = 2'h1,
        WR_HI = 2'h2
    } dbsac_wr_st_t;

    function automatic int unsigned org_dw(input int unsigned org);
        case (org)
            ORG_X8: return DW_X8;
            ORG_X9: return DW_X9;
            ORG_X18: return DW_X18;
            default: return DW_X36;
        endcase
    endfunction

    function automatic int unsigned org_aw(input int unsigned org);
        case (org)
            ORG_X8: return EXT_AW_X8;
            ORG_X9: return EXT_AW_X9;
            ORG_X18: return EXT_AW_X18;
            default: return EXT_AW_X36;
        endcase
    endfunction

endpackage

//--- dbsac_sync2.sv
`timescale 1ns/100ps
// ****************************************
// two flop synchroniser, one per bit
// ****************************************
module dbsac_sync2 #(
    parameter int unsigned W = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    if (W < 1) begin : g_bad_w
        $error("dbsac_sync2: W must be at least one");
    end

    // meta_ff is read by q_ff alone
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_ff <= '0;
            q_ff <= '0;
        end else begin
            meta_ff <= d;
            q_ff <= meta_ff;
        end
    end

    assign q = q_ff;
endmodule // dbsac_sync2

//--- dbsac_top.sv
`timescale 1ns/100ps
module dbsac_top
    import dbsac_pkg::*;
#(
    parameter int unsigned ORG = ORG_X18,
    parameter int unsigned ROW_W = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic k,
    input wire logic k_n,
    input wire logic c,
    input wire logic c_n,
    input wire logic single_clk_mode,
    input wire logic load_strobe_n,
    input wire logic read_not_write,
    input wire logic [org_aw(ORG)-1:0] addr,
    input wire logic [org_dw(ORG)-1:0] dq_in,
    output logic [org_dw(ORG)-1:0] dq_out,
    output logic dq_oe_n
);
    localparam int unsigned DW = org_dw(ORG);
    localparam int unsigned AW = org_aw(ORG);
    localparam int unsigned SW = 7 + AW + DW;
    localparam bit NARROW = (ORG == ORG_X8) || (ORG == ORG_X9);

    // storage is trimmed to 2**ROW_W rows per array; upper address bits alias
    if (ORG > ORG_X36 || ROW_W < 1 || ROW_W >= AW) begin : g_bad_cfg
        $error("dbsac_top: unsupported ORG or ROW_W");
    end

    // ****************************************
    // pin synchronisers and edge finders
    // ****************************************
    logic [SW-1:0] sync_q;
    logic k_s, kn_s, c_s, cn_s, single_s, load_n_s, rw_s;
    logic [AW-1:0] addr_s;
    logic [DW-1:0] dq_s;
    logic k_d_ff, kn_d_ff, oc_d_ff, ocn_d_ff;
    logic k_rise, kn_rise, oc_rise, ocn_rise, oc_s, ocn_s;

    dbsac_sync2 #(
        .W(SW)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({k, k_n, c, c_n, single_clk_mode, load_strobe_n, read_not_write, addr, dq_in}),
        .q(sync_q)
    );

    assign {k_s, kn_s, c_s, cn_s, single_s, load_n_s, rw_s, addr_s, dq_s} = sync_q;
    assign oc_s = single_s ? k_s : c_s;
    assign ocn_s = single_s ? kn_s : cn_s;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            k_d_ff <= 1'h0;
            kn_d_ff <= 1'h0;
            oc_d_ff <= 1'h0;
            ocn_d_ff <= 1'h0;
        end else begin
            k_d_ff <= k_s;
            kn_d_ff <= kn_s;
            oc_d_ff <= oc_s;
            ocn_d_ff <= ocn_s;
        end
    end

    assign k_rise = k_s & ~k_d_ff;
    assign kn_rise = kn_s & ~kn_d_ff;
    assign oc_rise = oc_s & ~oc_d_ff;
    assign ocn_rise = ocn_s & ~ocn_d_ff;

    // ****************************************
    // command capture
    // ****************************************
    logic load_ok;
    logic [AW:0] base_in;
    logic [AW:0] rd_base_ff;
    logic [AW:0] wr_base_ff;
    logic rd_pend_ff;

    assign load_ok = k_rise & ~load_n_s;
    // narrow widths pad a zero below the pins; wide ones seed from the pin
    assign base_in = NARROW ? {addr_s, 1'h0} : {1'h0, addr_s};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_base_ff <= '0;
            wr_base_ff <= '0;
        end else if (load_ok) begin
            if (rw_s) begin
                rd_base_ff <= base_in;
            end else begin
                wr_base_ff <= base_in;
            end
        end
    end

    // a new read on the same edge that takes the old one wins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_pend_ff <= 1'h0;
        end else if (load_ok && rw_s) begin
            rd_pend_ff <= 1'h1;
        end else if (oc_rise) begin
            rd_pend_ff <= 1'h0;
        end
    end

    // ****************************************
    // write burst capture
    // ****************************************
    dbsac_wr_st_t wst_ff;
    logic [DW-1:0] wd0_ff;
    logic commit;
    logic [AW:0] commit_base_ff;

    assign commit = (wst_ff == WR_HI) && k_rise;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wst_ff <= WR_IDLE;
            wd0_ff <= '0;
        end else begin
            case (wst_ff)
                WR_LO: begin
                    if (kn_rise) begin
                        wd0_ff <= dq_s;
                        wst_ff <= WR_HI;
                    end
                end
                default: begin
                    if (load_ok && !rw_s) begin
                        wst_ff <= WR_LO;
                    end else if (wst_ff == WR_HI && k_rise) begin
                        wst_ff <= WR_IDLE;
                    end
                end
            endcase
        end
    end

    // the commit address must survive a fresh write load on the commit edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            commit_base_ff <= '0;
        end else if (wst_ff == WR_LO && kn_rise) begin
            commit_base_ff <= wr_base_ff;
        end
    end

    // ****************************************
    // two internal arrays
    // ****************************************
    logic [DW-1:0] mem_ff [NUM_ARRAYS][2**ROW_W];
    logic [ROW_W-1:0] wr_row, rd_row;
    logic [DW-1:0] rd_word0, rd_word1;

    assign wr_row = commit_base_ff[ROW_W:1];
    assign rd_row = rd_base_ff[ROW_W:1];

    for (genvar b = 0; b < NUM_ARRAYS; b++) begin : g_array
        always_ff @(posedge clk) begin
            if (commit) begin
                // first word lands in the seeded array, second in the other
                if (commit_base_ff[0] == 1'(b)) begin
                    mem_ff[b][wr_row] <= wd0_ff;
                end else begin
                    mem_ff[b][wr_row] <= dq_s;
                end
            end
        end
    end

    assign rd_word0 = mem_ff[rd_base_ff[0]][rd_row];
    assign rd_word1 = mem_ff[~rd_base_ff[0]][rd_row];

    // ****************************************
    // read data out
    // ****************************************
    dbsac_rd_st_t rst_ff;
    logic [DW-1:0] dq_out_ff;
    logic dq_oe_n_ff;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rst_ff <= RD_IDLE;
            dq_out_ff <= '0;
            dq_oe_n_ff <= DQ_OE_OFF;
        end else begin
            case (rst_ff)
                RD_WORD1: begin
                    if (ocn_rise) begin
                        dq_out_ff <= rd_word1;
                        rst_ff <= RD_TAIL;
                    end
                end
                default: begin
                    if (oc_rise && rd_pend_ff) begin
                        dq_out_ff <= rd_word0;
                        dq_oe_n_ff <= 1'h0;
                        rst_ff <= RD_WORD1;
                    end else if (oc_rise) begin
                        dq_oe_n_ff <= DQ_OE_OFF;
                        rst_ff <= RD_IDLE;
                    end
                end
            endcase
        end
    end

    assign dq_out = dq_out_ff;
    assign dq_oe_n = dq_oe_n_ff;

    // ****************************************
    // checks
    // ****************************************
    chk_addr_ignore: assert property (@(posedge clk) disable iff (!rst_n)
        k_rise && load_n_s |=> $stable(rd_base_ff) && $stable(wr_base_ff))
        else $error("address taken while deselected");
    chk_read_dir: assert property (@(posedge clk) disable iff (!rst_n)
        load_ok && rw_s |=> rd_pend_ff && rd_base_ff == $past(base_in))
        else $error("read load not taken");
    chk_write_dir: assert property (@(posedge clk) disable iff (!rst_n)
        load_ok && !rw_s |=> wst_ff == WR_LO && wr_base_ff == $past(base_in))
        else $error("write load not taken");
    chk_k_edge: assert property (@(posedge clk) disable iff (!rst_n)
        !k_rise |=> $stable(rd_base_ff) && $stable(wr_base_ff))
        else $error("address captured off the true clock rise");
    chk_seed_bit: assert property (@(posedge clk) disable iff (!rst_n)
        load_ok |=> ($past(rw_s) ? rd_base_ff[0] : wr_base_ff[0])
            == (NARROW ? 1'h0 : $past(addr_s[0])))
        else $error("burst seed bit wrong");
    chk_burst_pair: assert property (@(posedge clk) disable iff (!rst_n)
        rst_ff == RD_WORD1 && ocn_rise |=> dq_out_ff == $past(rd_word1) && !dq_oe_n_ff)
        else $error("second burst word wrong");
    chk_oe_idle: assert property (@(posedge clk) disable iff (!rst_n)
        oc_rise && !rd_pend_ff && rst_ff != RD_WORD1 |=> dq_oe_n_ff)
        else $error("outputs driven with no read");
    chk_out_clock: assert property (@(posedge clk) disable iff (!rst_n)
        !oc_rise && !ocn_rise |=> $stable(dq_out_ff) && $stable(dq_oe_n_ff))
        else $error("read data moved off the output clocks");
    chk_wr_capture: assert property (@(posedge clk) disable iff (!rst_n)
        wst_ff == WR_LO && kn_rise |=> wd0_ff == $past(dq_s) && wst_ff == WR_HI)
        else $error("write data not taken on complementary rise");
endmodule // dbsac_top

//--- dbsac_ctrl_model.sv
`timescale 1ns/100ps
// ****************************************
// controller model: clocks, commands, write data
// ****************************************
module dbsac_ctrl_model (
    output logic k,
    output logic k_n,
    output logic c,
    output logic c_n,
    output logic load_strobe_n,
    output logic read_not_write,
    output logic [20:0] addr,
    output logic [17:0] dq_in
);
    initial begin
        k = 1'h0;
        c = 1'h0;
        load_strobe_n = 1'h1;
        read_not_write = 1'h1;
        addr = 21'h0;
        dq_in = 18'h0;
    end
    // edges sit on 50 ns marks, half a cycle away from the system clock rising edges
    always #200 k = ~k;
    assign k_n = ~k;
    // output pair moves together, a fixed board delay behind k
    always @(k) c <= #100 k;
    assign c_n = ~c;
    // command held 200 ns either side of its k rise, as the synchronisers need
    task automatic access(
        input logic rd,
        input logic ld_n,
        input logic [20:0] a,
        input logic [17:0] w0,
        input logic [17:0] w1
    );
        @(negedge k);
        load_strobe_n = ld_n;
        read_not_write = rd;
        addr = a;
        @(posedge k);
        #100 dq_in = w0;
        #100;
        load_strobe_n = 1'h1;
        read_not_write = ~rd;
        addr = ~a;
        #150 dq_in = w1;
        // released data shows the inverse so a stale value cannot match
        #200 dq_in = ~w1;
    endtask
endmodule // dbsac_ctrl_model

//--- tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic clk, rst_n, k, k_n, c, c_n, single_clk_mode, load_strobe_n, read_not_write, dq_oe_n;
    logic [20:0] addr;
    logic [17:0] dq_in, dq_out;
    logic [7:0] dq_out_x8;
    logic dq_oe_x8_n;
    int n_errors;
    int total_checks;

    dbsac_top #(.ORG(dbsac_pkg::ORG_X18), .ROW_W(4)) i_dut (
        .clk(clk), .rst_n(rst_n), .k(k), .k_n(k_n), .c(c), .c_n(c_n),
        .single_clk_mode(single_clk_mode), .load_strobe_n(load_strobe_n),
        .read_not_write(read_not_write), .addr(addr), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe_n(dq_oe_n)
    );
    // byte-wide copy on the same pins, to see the forced zero burst bit
    dbsac_top #(.ORG(dbsac_pkg::ORG_X8), .ROW_W(4)) i_dut_x8 (
        .clk(clk), .rst_n(rst_n), .k(k), .k_n(k_n), .c(c), .c_n(c_n),
        .single_clk_mode(single_clk_mode), .load_strobe_n(load_strobe_n),
        .read_not_write(read_not_write), .addr(addr), .dq_in(dq_in[7:0]),
        .dq_out(dq_out_x8), .dq_oe_n(dq_oe_x8_n)
    );
    dbsac_ctrl_model i_ctrl (
        .k(k), .k_n(k_n), .c(c), .c_n(c_n), .load_strobe_n(load_strobe_n),
        .read_not_write(read_not_write), .addr(addr), .dq_in(dq_in)
    );

    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    // ****************************************
    // checking and closing
    // ****************************************
    task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ****************************************
    // bus cycles
    // ****************************************
    task automatic wr(input logic [20:0] a, input logic [17:0] w0, input logic [17:0] w1);
        i_ctrl.access(1'h0, 1'h0, a, w0, w1);
    endtask

    // words are 200 ns apart on either output clock, so word1 is 4 cycles after word0
    task automatic rd_chk(input logic [20:0] a, input logic [17:0] e0, input logic [17:0] e1);
        int n;
        n = 0;
        fork
            i_ctrl.access(1'h1, 1'h0, a, 18'h0, 18'h0);
            begin
                while (dq_oe_n !== 1'h0 && n < 40) begin
                    @(negedge clk);
                    n++;
                end
                chk("word0", e0, dq_out);
                repeat (4) @(negedge clk);
                chk("word1", e1, dq_out);
                chk("oe_burst", 18'h0, 18'(dq_oe_n));
            end
        join
        repeat (8) @(negedge clk);
        chk("oe_idle", 18'h1, 18'(dq_oe_n));
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset_idle();
        @(negedge clk);
        chk("oe_reset", 18'h1, 18'(dq_oe_n));
        chk("dq_reset", 18'h0, dq_out);
        chk("addr_width", 18'h15, 18'($bits(i_dut.addr)));
        chk("addr_width_x8", 18'h15, 18'($bits(i_dut_x8.addr)));
    endtask

    task automatic t_burst_pair();
        wr(21'h5, 18'h2A5C3, 18'h15A3C);
        rd_chk(21'h5, 18'h2A5C3, 18'h15A3C);
        rd_chk(21'h4, 18'h15A3C, 18'h2A5C3);
        wr(21'h6, 18'h01234, 18'h3ABCD);
        rd_chk(21'h7, 18'h3ABCD, 18'h01234);
    endtask

    task automatic t_deselect();
        // write-looking cycle with the load strobe high must leave storage alone
        i_ctrl.access(1'h0, 1'h1, 21'h5, 18'h3FFFF, 18'h00000);
        rd_chk(21'h5, 18'h2A5C3, 18'h15A3C);
    endtask

    // wide widths share a pair between addresses 2 and 3, byte-wide ones do not
    task automatic t_narrow();
        wr(21'h2, 18'h00011, 18'h00022);
        wr(21'h3, 18'h00033, 18'h00044);
        fork
            rd_chk(21'h2, 18'h00044, 18'h00033);
            begin
                while (dq_oe_x8_n !== 1'h0) begin
                    @(negedge clk);
                end
                chk("word0_x8", 18'h11, 18'(dq_out_x8));
                repeat (4) @(negedge clk);
                chk("word1_x8", 18'h22, 18'(dq_out_x8));
            end
        join
    endtask

    task automatic t_single_clock();
        @(posedge clk);
        single_clk_mode <= 1'h1;
        repeat (4) @(posedge clk);
        wr(21'h8, 18'h0F0F0, 18'h30303);
        rd_chk(21'h9, 18'h30303, 18'h0F0F0);
        rd_chk(21'h8, 18'h0F0F0, 18'h30303);
        @(posedge clk);
        single_clk_mode <= 1'h0;
        repeat (4) @(posedge clk);
        rd_chk(21'h8, 18'h0F0F0, 18'h30303);
    endtask

    initial begin
        rst_n = 1'h0;
        single_clk_mode = 1'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        t_reset_idle();
        repeat (4) @(posedge clk);
        t_burst_pair();
        t_deselect();
        t_narrow();
        t_single_clock();
        test_done();
    end

    // about fourteen bus cycles of 0.8 to 1.6 us each; allow several times that
    initial begin
        #60000;
        n_errors++;
        test_done();
    end
endmodule // tb_top
